// ===== logic/lpss_pkg.sv
// Constants for the low-power state sequencing controller
package lpss_pkg;
  localparam int unsigned CLK_MHZ         = 250;
  localparam int unsigned SG_TO_STOP_BCLK = 100;
  localparam int unsigned SG_TO_SLP_BCLK  = 100;
  localparam int unsigned SLP_TO_STOP_BCLK = 10;
  localparam int unsigned STOP_CLOCK_REQUEST_N_HOLD_BCLK = 8;
  localparam int unsigned SLP_EXIT_HOLD_BCLK = 10;
  localparam int unsigned PLL_LOCK_US     = 30;
  localparam int unsigned PLL_LOCK_CYC    = PLL_LOCK_US * CLK_MHZ;
  localparam int unsigned GHI_IGNORE_US   = 10;
  localparam int unsigned GHI_IGNORE_CYC  = GHI_IGNORE_US * CLK_MHZ;
  localparam int unsigned MODE_SETUP_NS   = 150;
  localparam int unsigned MODE_SETUP_CYC  = (MODE_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SETTLE_NS       = 150;
  localparam int unsigned SETTLE_CYC      = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned BCLK_DIV        = 2;
  localparam int unsigned CNT_W           = 16;

  typedef enum logic [3:0] {
    LPSS_NORMAL, LPSS_STOP_CLOCK_REQUEST_N, LPSS_GRANT, LPSS_SLEEP, LPSS_SLP_WAIT,
    LPSS_DEEP, LPSS_MODE_SET, LPSS_RESTART, LPSS_LOCK, LPSS_SLP_EXIT,
    LPSS_STP_EXIT
  } lpss_state_e;
endpackage : lpss_pkg

// ===== logic/lpss_bclk_div.sv
// Bus clock divider: free toggle with stop control, tick per bus clock
`timescale 1ns/100ps
`default_nettype none
module lpss_bclk_div #(
  parameter int unsigned DIV = 2
) (
  input  wire  logic clock,
  input  wire  logic rst_b,
  input  wire  logic run,
  output var   logic bclk,
  output var   logic tick
);
  logic [7:0] cnt_q, cnt_d;
  logic       bclk_q, bclk_d;
  logic       tick_q, tick_d;

  always_comb begin
    cnt_d  = cnt_q;
    bclk_d = bclk_q;
    tick_d = 1'b0;
    if (run || bclk_q) begin
      if (cnt_q == 8'(DIV - 1)) begin
        cnt_d  = 8'h00;
        bclk_d = ~bclk_q;
        tick_d = ~bclk_q;
      end else begin
        cnt_d = cnt_q + 8'h01;
      end
    end else begin
      cnt_d = 8'h00;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q  <= 8'h00;
      bclk_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      bclk_q <= bclk_d;
      tick_q <= tick_d;
    end
  end

  assign bclk = bclk_q;
  assign tick = tick_q;
endmodule : lpss_bclk_div
`default_nettype wire

// ===== logic/lpss_ctrl.sv
// Power-management controller sequencing processor low-power states
// Overview of operation
// R1 - Bus clock runs 100 clocks after grant
// R2 - Inputs stable at grant cycle completion
// R3 - Processor relocks PLL within 30 us
// R4 - Stop request held until PLL lock
// R5 - Inputs held 8 clocks after stop release
// R6 - Quick start: inputs constant except reset, priority
// R7 - Sleep request no sooner than 100 clocks
// R8 - Inputs stable when sleep request asserts
// R9 - Clock stops 10 clocks after sleep request
// R10 - Sleep request held until PLL lock
// R11 - Stop request held 10 clocks after sleep
// R12 - Inputs held 10 clocks after sleep release
// R13 - Sleep state: inputs constant except reset
// R14 - Mode select ignored 10 us after stop
// R15 - Mode set 150 ns before, held 30 us
// R16 - Restarted clock settles within 150 ns
// R17 - Normal, grant, sleep, deep; reverse exit
`timescale 1ns/100ps
`default_nettype none
module lpss_ctrl #(
  parameter int unsigned PLL_LOCK_CYC   = lpss_pkg::PLL_LOCK_CYC,
  parameter int unsigned GHI_IGNORE_CYC = lpss_pkg::GHI_IGNORE_CYC
) (
  input  wire  logic clock,
  input  wire  logic rst_b,
  input  wire  logic enter_req,
  input  wire  logic deep_req,
  input  wire  logic wake_req,
  input  wire  logic mode_change,
  input  wire  logic mode_value_n,
  input  wire  logic grant_done,
  output var   logic bclk,
  output var   logic stop_clock_request_n,
  output var   logic sleep_request_n,
  output var   logic perf_mode_select_n,
  output var   logic inputs_frozen,
  output var   logic busy
);
  logic rst_m_q, rst_s_q;
  logic gd_m_q, gd_s_q;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_m_q <= 1'b0;
      rst_s_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_s_q <= rst_m_q;
    end
  end

  always_ff @(posedge clock or negedge rst_s_q) begin
    if (!rst_s_q) begin
      gd_m_q <= 1'b0;
      gd_s_q <= 1'b0;
    end else begin
      gd_m_q <= grant_done;
      gd_s_q <= gd_m_q;
    end
  end

  lpss_pkg::lpss_state_e st_q, st_d;
  logic [lpss_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic stp_q, stp_d, slp_q, slp_d, ghi_q, ghi_d;
  logic frz_q, frz_d, run_q, run_d, deep_q, deep_d;
  logic busy_q, busy_d;
  logic tick;

  lpss_bclk_div #(
    .DIV (lpss_pkg::BCLK_DIV)
  ) u_div (
    .clock (clock),
    .rst_b (rst_s_q),
    .run   (run_q),
    .bclk  (bclk),
    .tick  (tick)
  );

  function automatic logic [lpss_pkg::CNT_W-1:0] lim(input int unsigned v);
    lim = lpss_pkg::CNT_W'(v - 1);
  endfunction : lim

  // Full count: a bus clock rise on the strobe's own edge is not one
  function automatic logic [lpss_pkg::CNT_W-1:0] hold_lim(input int unsigned v);
    hold_lim = lpss_pkg::CNT_W'(v);
  endfunction : hold_lim

  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    stp_d  = stp_q;
    slp_d  = slp_q;
    ghi_d  = ghi_q;
    frz_d  = frz_q;
    run_d  = run_q;
    deep_d = deep_q;
    busy_d = (st_q != lpss_pkg::LPSS_NORMAL);
    unique case (st_q)
      lpss_pkg::LPSS_NORMAL: begin
        if (enter_req) begin
          stp_d  = 1'b1;
          deep_d = deep_req;
          st_d   = lpss_pkg::LPSS_STOP_CLOCK_REQUEST_N;
        end
      end
      lpss_pkg::LPSS_STOP_CLOCK_REQUEST_N: begin
        if (gd_s_q) begin
          frz_d = 1'b1; // [R2] [R6]
          cnt_d = '0;
          st_d  = lpss_pkg::LPSS_GRANT;
        end
      end
      lpss_pkg::LPSS_GRANT: begin
        if (deep_q) begin
          if (tick) begin
            cnt_d = cnt_q + 1'b1;
          end
          if (tick && cnt_q >= lim(lpss_pkg::SG_TO_SLP_BCLK)) begin
            slp_d = 1'b1; // [R7] [R8] [R1]
            cnt_d = '0;
            st_d  = lpss_pkg::LPSS_SLEEP;
          end
        end else if (wake_req) begin
          stp_d = 1'b0;
          cnt_d = '0;
          st_d  = lpss_pkg::LPSS_STP_EXIT;
        end
      end
      lpss_pkg::LPSS_SLEEP: begin
        if (tick) begin
          cnt_d = cnt_q + 1'b1;
        end
        if (tick && cnt_q >= hold_lim(lpss_pkg::SLP_TO_STOP_BCLK)) begin
          run_d = 1'b0; // [R9] [R13]
          cnt_d = '0;
          st_d  = lpss_pkg::LPSS_DEEP;
        end
      end
      lpss_pkg::LPSS_DEEP: begin
        if (cnt_q < lim(GHI_IGNORE_CYC) + 1'b1) begin
          cnt_d = cnt_q + 1'b1;
        end
        if (wake_req && cnt_q >= lim(GHI_IGNORE_CYC)) begin
          if (mode_change) begin
            ghi_d = mode_value_n; // [R14]
          end
          cnt_d = '0;
          st_d  = lpss_pkg::LPSS_MODE_SET;
        end
      end
      lpss_pkg::LPSS_MODE_SET: begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q >= lim(lpss_pkg::MODE_SETUP_CYC)) begin
          run_d = 1'b1; // [R15] [R16]
          cnt_d = '0;
          st_d  = lpss_pkg::LPSS_LOCK;
        end
      end
      lpss_pkg::LPSS_LOCK: begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q >= lim(PLL_LOCK_CYC + lpss_pkg::SETTLE_CYC)) begin
          slp_d = 1'b0; // [R3] [R10] [R4] [R15]
          cnt_d = '0;
          st_d  = lpss_pkg::LPSS_SLP_EXIT;
        end
      end
      lpss_pkg::LPSS_SLP_EXIT: begin
        if (tick) begin
          cnt_d = cnt_q + 1'b1;
        end
        if (tick && cnt_q >= hold_lim(lpss_pkg::SLP_EXIT_HOLD_BCLK)) begin
          stp_d = 1'b0; // [R11] [R12] [R17]
          cnt_d = '0;
          st_d  = lpss_pkg::LPSS_STP_EXIT;
        end
      end
      lpss_pkg::LPSS_STP_EXIT: begin
        if (tick) begin
          cnt_d = cnt_q + 1'b1;
        end
        if (tick && cnt_q >= hold_lim(lpss_pkg::STOP_CLOCK_REQUEST_N_HOLD_BCLK)) begin
          frz_d = 1'b0; // [R5]
          st_d  = lpss_pkg::LPSS_NORMAL;
        end
      end
      default: st_d = lpss_pkg::LPSS_NORMAL;
    endcase
  end

  always_ff @(posedge clock or negedge rst_s_q) begin
    if (!rst_s_q) begin
      st_q   <= lpss_pkg::LPSS_NORMAL;
      cnt_q  <= '0;
      stp_q  <= 1'b0;
      slp_q  <= 1'b0;
      ghi_q  <= 1'b1;
      frz_q  <= 1'b0;
      run_q  <= 1'b1;
      deep_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      stp_q  <= stp_d;
      slp_q  <= slp_d;
      ghi_q  <= ghi_d;
      frz_q  <= frz_d;
      run_q  <= run_d;
      deep_q <= deep_d;
      busy_q <= busy_d;
    end
  end

  assign stop_clock_request_n = ~stp_q;
  assign sleep_request_n      = ~slp_q;
  assign perf_mode_select_n   = ghi_q;
  assign inputs_frozen        = frz_q;
  assign busy                 = busy_q;

  // Bus clocks seen since each strobe last moved, for the hold checks
  localparam int unsigned AGE_W = 8;
  logic [AGE_W-1:0] stp_age_q, stp_age_d;
  logic [AGE_W-1:0] slp_age_q, slp_age_d;
  logic [AGE_W-1:0] frz_age_q, frz_age_d;

  function automatic logic [AGE_W-1:0] age_next(input logic [AGE_W-1:0] a,
                                                input logic moved,
                                                input logic t);
    if (moved) begin
      age_next = '0;
    end else if (t && a != '1) begin
      age_next = a + 1'b1;
    end else begin
      age_next = a;
    end
  endfunction : age_next

  always_comb begin
    stp_age_d = age_next(stp_age_q, stp_d != stp_q, tick);
    slp_age_d = age_next(slp_age_q, slp_d != slp_q, tick);
    frz_age_d = age_next(frz_age_q, frz_d != frz_q, tick);
  end

  // Saturated after reset, so a first quick start is not flagged
  always_ff @(posedge clock or negedge rst_s_q) begin
    if (!rst_s_q) begin
      stp_age_q <= '1;
      slp_age_q <= '1;
      frz_age_q <= '1;
    end else begin
      stp_age_q <= stp_age_d;
      slp_age_q <= slp_age_d;
      frz_age_q <= frz_age_d;
    end
  end

  // Sleep request only while stop request stands
  sleep_in_stop_a: assert property ( // [R17]
    @(posedge clock) disable iff (!rst_s_q) slp_q |-> stp_q)
    else $error("sleep without stop request");
  // Clock stopped only with sleep request
  stop_needs_sleep_a: assert property ( // [R9]
    @(posedge clock) disable iff (!rst_s_q) !run_q |-> slp_q)
    else $error("clock stopped without sleep");
  // Inputs frozen through sleep
  frozen_sleep_a: assert property ( // [R13]
    @(posedge clock) disable iff (!rst_s_q) slp_q |-> frz_q)
    else $error("inputs not frozen in sleep");
  // Mode select stable while clock running and sleeping
  mode_hold_a: assert property ( // [R15]
    @(posedge clock) disable iff (!rst_s_q)
    (run_q && slp_q) |=> $stable(ghi_q))
    else $error("mode moved");
  // Sleep release only after clock restarted
  slp_rel_a: assert property ( // [R10]
    @(posedge clock) disable iff (!rst_s_q) $fell(slp_q) |-> run_q)
    else $error("sleep released early");
  // Stop release never with sleep asserted
  stp_rel_a: assert property ( // [R11]
    @(posedge clock) disable iff (!rst_s_q) $fell(stp_q) |-> !slp_q)
    else $error("stop released early");
  // Freeze lifts only after stop release
  frz_rel_a: assert property ( // [R5]
    @(posedge clock) disable iff (!rst_s_q)
    $fell(frz_q) |-> !stp_q && !$past(stp_q))
    else $error("freeze early");

  // Restart, then sleep request kept through the first lock cycles
  sequence clk_restart_s;
    $rose(run_q);
  endsequence
  sequence slp_kept_s;
    slp_q [*8];
  endsequence
  lock_wait_a: assert property ( // [R3]
    @(posedge clock) disable iff (!rst_s_q) clk_restart_s |-> slp_kept_s)
    else $error("lock wait short");

  // New mode select, then the clock stays stopped through its first 8 setup cycles
  sequence mode_moved_s;
    $changed(ghi_q);
  endsequence
  sequence clk_held_s;
    !run_q [*8];
  endsequence
  mode_setup_a: assert property ( // [R15]
    @(posedge clock) disable iff (!rst_s_q) mode_moved_s |-> clk_held_s)
    else $error("mode set too close to restart");

  // Sleep request a full grant wait after the grant cycle
  slp_delay_a: assert property ( // [R7]
    @(posedge clock) disable iff (!rst_s_q)
    $rose(slp_q) |-> frz_age_q >= AGE_W'(lpss_pkg::SG_TO_SLP_BCLK))
    else $error("sleep request too soon after grant");
  // Clock stop a full wait after sleep request
  clk_stop_a: assert property ( // [R9]
    @(posedge clock) disable iff (!rst_s_q)
    $fell(run_q) |-> slp_age_q >= AGE_W'(lpss_pkg::SLP_TO_STOP_BCLK))
    else $error("clock stopped too soon after sleep");
  // Stop request kept a full hold after sleep release
  stp_hold_a: assert property ( // [R11]
    @(posedge clock) disable iff (!rst_s_q)
    $fell(stp_q) |-> slp_age_q >= AGE_W'(lpss_pkg::SLP_EXIT_HOLD_BCLK))
    else $error("stop released too soon after sleep");
  // Inputs kept a full hold after stop release
  frz_hold_a: assert property ( // [R5]
    @(posedge clock) disable iff (!rst_s_q)
    $fell(frz_q) |-> stp_age_q >= AGE_W'(lpss_pkg::STOP_CLOCK_REQUEST_N_HOLD_BCLK))
    else $error("inputs released too soon after stop");
endmodule : lpss_ctrl
`default_nettype wire

// ===== tb/lpss_cpu_model.sv
// Processor model: stop grant reply, PLL relock, mode sampling
`timescale 1ns/100ps
`default_nettype none
module lpss_cpu_model #(
  parameter int unsigned LOCK = 20,
  parameter int unsigned IGN  = 20
) (
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic bclk,
  input  wire logic stop_clock_request_n,
  input  wire logic perf_mode_select_n,
  output var  logic grant_done,
  output var  logic stopped,
  output var  logic locked,
  output var  logic mode_seen
);
  logic        bclk_q;
  logic [15:0] idle_q;
  logic [15:0] run_q;
  logic [3:0]  gnt_q;
  assign stopped = idle_q > 16'h0008;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      {bclk_q, idle_q, run_q, gnt_q, grant_done} <= '0;
      locked    <= 1'b1;
      mode_seen <= 1'b1;
    end else begin
      bclk_q <= bclk;
      idle_q <= (bclk != bclk_q) ? 16'h0000 : idle_q + 16'h0001;
      if (stop_clock_request_n) begin
        gnt_q      <= 4'h0;
        grant_done <= 1'b0;
      end else if (gnt_q != 4'hB) begin
        gnt_q <= gnt_q + 4'h1;
      end else begin
        grant_done <= 1'b1;
      end
      if (stopped) begin
        locked <= 1'b0;
        run_q  <= 16'h0000;
      end else if (!locked) begin
        run_q  <= run_q + 16'h0001;
        locked <= run_q >= 16'(LOCK - 1);
      end
      if (stopped && bclk != bclk_q && idle_q >= 16'(IGN)) begin
        mode_seen <= perf_mode_select_n;
      end
    end
  end
endmodule : lpss_cpu_model
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the low-power state sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic enter_req = 1'b0;
  logic deep_req = 1'b0;
  logic wake_req = 1'b0;
  logic mode_change = 1'b0;
  logic mode_value_n = 1'b1;
  logic grant_done, bclk, stop_n, sleep_n, perf_n, frozen, busy;
  logic stopped, locked, mode_seen;
  int   errors = 0;
  int   check_count = 0;
  int   cyc = 0;
  always #2 clock = ~clock;
  lpss_ctrl #(.PLL_LOCK_CYC(20), .GHI_IGNORE_CYC(20)) dut_u (
    .clock(clock), .rst_b(rst_b), .enter_req(enter_req),
    .deep_req(deep_req), .wake_req(wake_req), .mode_change(mode_change),
    .mode_value_n(mode_value_n), .grant_done(grant_done), .bclk(bclk),
    .stop_clock_request_n(stop_n), .sleep_request_n(sleep_n),
    .perf_mode_select_n(perf_n), .inputs_frozen(frozen), .busy(busy));
  lpss_cpu_model #(.LOCK(20), .IGN(20)) cpu_u (
    .clock(clock), .rst_b(rst_b), .bclk(bclk),
    .stop_clock_request_n(stop_n), .perf_mode_select_n(perf_n),
    .grant_done(grant_done), .stopped(stopped), .locked(locked),
    .mode_seen(mode_seen));
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude
  task automatic check(input logic seen, input logic exp, input string m);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask : check
  task automatic wait_for(ref logic s, input logic v, output int n);
    n = 0;
    while (s !== v && n < 3000) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n >= 3000) check(1'b0, 1'b1, "wait ran out");
  endtask : wait_for
  // One-cycle strobe of enter, wake and mode change, changed just after the edge; deep_req is left as set
  task automatic req(input logic e, input logic d, input logic w,
                     input logic m);
    enter_req   = e;
    deep_req    = d;
    wake_req    = w;
    mode_change = m;
    @(posedge clock);
    #1;
    enter_req   = 1'b0;
    wake_req    = 1'b0;
    mode_change = 1'b0;
  endtask : req
  task automatic refused_wake();
    req(1'b0, 1'b0, 1'b1, 1'b0);
    repeat (3) @(posedge clock);
    #1;
    check(busy, 1'b0, "wake taken in normal");
    check(stop_n, 1'b1, "stray stop request");
  endtask : refused_wake
  task automatic quick_start();
    int n;
    req(1'b1, 1'b0, 1'b0, 1'b0);
    check(stop_n, 1'b0, "stop request late");
    wait_for(frozen, 1'b1, n);
    repeat (20) @(posedge clock);
    #1;
    check(frozen, 1'b1, "inputs released");
    check(sleep_n, 1'b1, "sleep in quick start");
    req(1'b0, 1'b0, 1'b1, 1'b0);
    wait_for(stop_n, 1'b1, n);
    wait_for(frozen, 1'b0, n);
    check(logic'(n >= 32), 1'b1, "stop hold short");
    wait_for(busy, 1'b0, n);
  endtask : quick_start
  task automatic deep_cycle(input logic v, input logic m);
    int n;
    req(1'b1, 1'b1, 1'b0, 1'b0);
    wait_for(grant_done, 1'b1, n);
    wait_for(sleep_n, 1'b0, n);
    check(logic'(n >= 400), 1'b1, "sleep too early");
    check(frozen, 1'b1, "inputs not frozen");
    wait_for(stopped, 1'b1, n);
    check(logic'(n >= 48), 1'b1, "clock stopped early");
    repeat (30) @(posedge clock);
    #1;
    mode_value_n = m ? v : ~v;
    req(1'b0, 1'b0, 1'b1, m);
    wait_for(stopped, 1'b0, n);
    check(perf_n, v, "mode late");
    wait_for(sleep_n, 1'b1, n);
    check(locked, 1'b1, "sleep left before lock");
    check(stop_n, 1'b0, "exit order");
    check(stopped, 1'b0, "clock not running");
    wait_for(stop_n, 1'b1, n);
    check(logic'(n >= 40), 1'b1, "stop after sleep short");
    check(locked, 1'b1, "stop left before lock");
    wait_for(frozen, 1'b0, n);
    check(logic'(n >= 32), 1'b1, "input hold short");
    check(mode_seen, v, "mode not taken");
    wait_for(busy, 1'b0, n);
  endtask : deep_cycle
  always @(posedge clock) begin
    cyc++;
    if (cyc == 8000) begin
      errors++;
      conclude();
    end
  end
  initial begin
    repeat (10) @(posedge clock);
    #1;
    rst_b = 1'b1;
    repeat (3) @(posedge clock);
    #1;
    refused_wake();
    quick_start();
    deep_cycle(1'b0, 1'b1);
    deep_cycle(1'b1, 1'b1);
    deep_cycle(1'b1, 1'b0);
    conclude();
  end
endmodule : tb_top
`default_nettype wire
